//--- rtl/cmc_top.sv
// connection memory channel control: per-channel switching, loopback, oe and control-channel output
// Operation
// - loopback bit set takes receive data from own transmit data, same stream/channel.
// - bit 14 chooses variable (low) or constant (high) throughput delay.
// - processor-channel bit set transmits the word's low byte directly.
// - processor-channel bit clear reads stored byte at source stream/channel address.
// - bit 12 driven on control-channel pin one channel early, stream 0 first.
// - bit 11 enables transmit driver; zero gives high impedance for the channel.
// - bits 8:7 give the source input stream number.
// - bits 6:0 give the source input channel number.
// - each frame carries channels 0 to 127 per stream.
module cmc_top
  import cmc_pkg::*;
#(
  parameter int STREAMS = NUM_STREAMS,
  parameter int CHANNELS = NUM_CHANNELS
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [10:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [NUM_STREAMS-1:0] rx_pin,
  input wire logic frame_pulse_pin,
  output logic [NUM_STREAMS-1:0] tx_out,
  output logic [NUM_STREAMS-1:0] tx_oe,
  output logic control_channel_out
);
  localparam int CW = $clog2(NUM_CHANNELS);
  localparam int SW = $clog2(NUM_STREAMS);
  localparam int FW = SW + CW + 8;

  // connection and data memories, indexed {stream, channel}
  logic [WORD_W-1:0] conn_q [NUM_STREAMS*NUM_CHANNELS];
  logic [7:0] data_q [NUM_STREAMS*NUM_CHANNELS];
  logic [7:0] dly_q [NUM_STREAMS*NUM_CHANNELS];
  logic [NUM_STREAMS-1:0] rx_s1_q;
  logic [NUM_STREAMS-1:0] rx_s2_q;
  logic fp_s1_q;
  logic fp_s2_q;
  logic fp_d_q;
  logic [2:0] tick_q;
  logic [2:0] bit_q;
  logic [CW-1:0] chan_q;
  logic [7:0] rx_sh_q [NUM_STREAMS];
  logic [7:0] tx_sh_q [NUM_STREAMS];
  logic [NUM_STREAMS-1:0] oe_q;
  logic [WORD_W-1:0] cco_word_q [NUM_STREAMS];
  logic cco_q;
  logic [15:0] rdata_q;
  logic [15:0] ctrl_q;
  logic [15:0] frames_q;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [FW-1:0] fifo_out;
  logic fifo_pop;
  logic [FW-1:0] fifo_in;
  logic fifo_push;
  logic bit_tick;
  logic frame_start;
  logic slot_end;
  logic [CW-1:0] chan_next;
  logic [CW-1:0] chan_ahead;
  logic rx_tick;
  wire logic [NUM_STREAMS-1:0] rx_bit;

  // pins from outside the domain pass two flops
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_s1_q <= '0;
      rx_s2_q <= '0;
      fp_s1_q <= 1'b0;
      fp_s2_q <= 1'b0;
      fp_d_q <= 1'b0;
    end
    else if (ce)
    begin
      rx_s1_q <= rx_pin;
      rx_s2_q <= rx_s1_q;
      fp_s1_q <= frame_pulse_pin;
      fp_s2_q <= fp_s1_q;
      fp_d_q <= fp_s2_q;
    end
  end

  assign frame_start = fp_s2_q && !fp_d_q;
  assign bit_tick = (tick_q == 3'(BIT_TIME_CYC-1));
  assign slot_end = bit_tick && (bit_q == 3'h7);
  // data pins reach us one cycle before the counter; sampling at the bit end would catch the next bit
  // so receive is taken mid-bit, well clear of both edges
  assign rx_tick = (tick_q == 3'(RX_TAP_CYC));
  assign chan_next = (chan_q == CW'(NUM_CHANNELS-1)) ? '0 : chan_q + 1'b1;
  assign chan_ahead = (chan_next == CW'(NUM_CHANNELS-1)) ? '0 : chan_next + 1'b1;

  // bit and channel timing, restarted by the frame pulse
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tick_q <= '0;
      bit_q <= '0;
      chan_q <= '0;
      frames_q <= '0;
    end
    else if (ce)
    begin
      if (frame_start)
      begin
        tick_q <= '0;
        bit_q <= '0;
        chan_q <= '0;
        frames_q <= frames_q + 1'b1;
      end
      else
      begin
        tick_q <= bit_tick ? '0 : tick_q + 1'b1;
        if (bit_tick)
        begin
          bit_q <= bit_q + 1'b1;
        end
        if (slot_end)
        begin
          chan_q <= chan_next;
        end
      end
    end
  end

  // per-stream serial datapath
  for (genvar s = 0; s < NUM_STREAMS; s++)
  begin : g_stream
    logic [WORD_W-1:0] w_next;
    logic [7:0] sel_byte;
    logic [SW+CW-1:0] src_idx;
    assign w_next = conn_q[{SW'(s), chan_next}];
    assign src_idx = {w_next[SRC_STREAM_HI:SRC_STREAM_LO], w_next[SRC_CHAN_HI:SRC_CHAN_LO]};
    // looped channel hears our own transmitted bit instead of the pin, for every consumer
    assign rx_bit[s] = conn_q[{SW'(s), chan_q}][BIT_LOOPBACK] ? tx_sh_q[s][7] : rx_s2_q[s];
    // constant delay reads the frame-old copy, variable the freshest byte
    assign sel_byte = w_next[BIT_PROC_CHAN] ? w_next[BYTE_HI:0] :
      (w_next[BIT_CONST_DELAY] ? dly_q[src_idx] : data_q[src_idx]);

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
      if (!arst_n)
      begin
        rx_sh_q[s] <= '0;
        tx_sh_q[s] <= '0;
        oe_q[s] <= 1'b0;
      end
      else if (ce)
      begin
        if (rx_tick)
        begin
          rx_sh_q[s] <= {rx_sh_q[s][6:0], rx_bit[s]};
        end
        if (bit_tick && bit_q == 3'h7)
        begin
          tx_sh_q[s] <= sel_byte;
          oe_q[s] <= w_next[BIT_OUT_EN];
        end
        else if (bit_tick)
        begin
          tx_sh_q[s] <= {tx_sh_q[s][6:0], 1'b0};
        end
      end
    end
  end

  // completed stream 0 receive bytes queue for the data memory write
  assign fifo_push = ce && rx_tick && (bit_q == 3'h7);
  assign fifo_pop = fifo_out_valid;

  // one byte per slot end per stream is too many for one port, so stream 0 is
  // queued and the others write directly; the fifo absorbs stalls from software
  assign fifo_in = {SW'(0), chan_q, rx_sh_q[0][6:0], rx_bit[0]};

  cmc_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .ce(ce),
    .in_data(fifo_in),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(!ctrl_q[0])
  );

  // data memory: current and frame-delayed copies
  always_ff @(posedge clk_sys)
  begin
    if (ce)
    begin
      if (fifo_pop && !ctrl_q[0])
      begin
        dly_q[fifo_out[FW-1:8]] <= data_q[fifo_out[FW-1:8]];
        data_q[fifo_out[FW-1:8]] <= fifo_out[7:0];
      end
      for (int s = 1; s < NUM_STREAMS; s++)
      begin
        if (rx_tick && bit_q == 3'h7)
        begin
          dly_q[{SW'(s), chan_q}] <= data_q[{SW'(s), chan_q}];
          data_q[{SW'(s), chan_q}] <= {rx_sh_q[s][6:0], rx_bit[s]};
        end
      end
    end
  end

  // control channel: next slot's bits, stream 0 first
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cco_q <= 1'b0;
      for (int s = 0; s < NUM_STREAMS; s++)
      begin
        cco_word_q[s] <= CONN_RESET;
      end
    end
    else if (ce && bit_tick)
    begin
      if (bit_q == 3'h7)
      begin
        for (int s = 0; s < NUM_STREAMS; s++)
        begin
          cco_word_q[s] <= conn_q[{SW'(s), chan_ahead}];
        end
        // bit time 0 of the new slot shows stream 0 straight from the word being loaded
        cco_q <= conn_q[{SW'(0), chan_ahead}][BIT_CTRL_OUT];
      end
      else
      begin
        // the flop shows the coming bit time, so look one stream ahead
        cco_q <= (bit_q < 3'(NUM_STREAMS - 1)) ? cco_word_q[SW'(bit_q + 3'h1)][BIT_CTRL_OUT] : 1'b0;
      end
    end
  end

  // connection memory writes; words reset to tristated, switched from 0
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < NUM_STREAMS*NUM_CHANNELS; i++)
      begin
        conn_q[i] <= CONN_RESET;
      end
      ctrl_q <= '0;
    end
    else if (ce && reg_wr)
    begin
      if (!reg_addr[10])
      begin
        conn_q[reg_addr[SW+CW-1:0]] <= reg_wdata; // bits 10:9 kept as written
      end
      else if (reg_addr == ADDR_CTRL)
      begin
        ctrl_q <= reg_wdata;
      end
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata_q <= '0;
    end
    else if (ce)
    begin
      rdata_q <= '0;
      if (reg_rd)
      begin
        if (!reg_addr[10])
        begin
          rdata_q <= conn_q[reg_addr[SW+CW-1:0]];
        end
        else if (reg_addr == ADDR_CTRL)
        begin
          rdata_q <= ctrl_q;
        end
        else if (reg_addr == ADDR_STATUS)
        begin
          rdata_q <= {2'b00, fifo_in_ready, fifo_out_valid, 5'h00, chan_q};
        end
        else if (reg_addr == ADDR_FIFO)
        begin
          rdata_q <= frames_q;
        end
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign control_channel_out = cco_q;
  for (genvar s = 0; s < NUM_STREAMS; s++)
  begin : g_out
    assign tx_out[s] = tx_sh_q[s][7];
    assign tx_oe[s] = oe_q[s];
  end

  // output enable only moves at a slot boundary, never inside a channel time
  oe_follows_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !(ce && bit_tick && bit_q == 3'h7) |=> $stable(tx_oe))
    else $error("oe update");
  // last channel wraps to zero, whether or not a frame pulse lands on it
  chan_wrap_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (chan_q == CW'(NUM_CHANNELS-1) && ce && slot_end) |=> chan_q == '0)
    else $error("channel wrap");
  // control-channel pin is quiet once every stream's bit has been shown
  cco_idle_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ce && bit_tick && bit_q > 3'h2 && bit_q < 3'h7) |=> !control_channel_out)
    else $error("control channel idle");
  // a looped stream 0 channel feeds its own transmitted bit back in
  loop_bit_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ce && rx_tick && conn_q[{SW'(0), chan_q}][BIT_LOOPBACK]) |=> rx_sh_q[0][0] == $past(tx_sh_q[0][7]))
    else $error("loopback bit");
  // processor byte and enable are loaded from the word fetched for the next slot
  proc_byte_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ce && slot_end && !frame_start && conn_q[{SW'(0), chan_next}][BIT_PROC_CHAN])
    |=> tx_sh_q[0] == $past(conn_q[{SW'(0), chan_next}][7:0]))
    else $error("processor byte");
  oe_load_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ce && slot_end && !frame_start) |=> tx_oe[0] == $past(conn_q[{SW'(0), chan_next}][BIT_OUT_EN]))
    else $error("output enable");
  rd_idle_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ce && !reg_rd) |=> reg_rdata == 16'h0000)
    else $error("read data idle");
endmodule : cmc_top

//--- rtl/cmc_pkg.sv
// package: connection word layout, stream geometry and register map
package cmc_pkg;
  localparam int NUM_STREAMS = 4;
  localparam int NUM_CHANNELS = 128;
  localparam int WORD_W = 16;
  localparam int BIT_LOOPBACK = 15;
  localparam int BIT_CONST_DELAY = 14;
  localparam int BIT_PROC_CHAN = 13;
  localparam int BIT_CTRL_OUT = 12;
  localparam int BIT_OUT_EN = 11;
  localparam int SRC_STREAM_HI = 8;
  localparam int SRC_STREAM_LO = 7;
  localparam int SRC_CHAN_HI = 6;
  localparam int SRC_CHAN_LO = 0;
  localparam int BYTE_HI = 7;
  localparam logic [15:0] CONN_RESET = 16'h0000;
  // address: bit 10 selects local regs, else {stream,channel} word index
  localparam logic [10:0] ADDR_CTRL = 11'h400;
  localparam logic [10:0] ADDR_STATUS = 11'h401;
  localparam logic [10:0] ADDR_FIFO = 11'h402;
  localparam int FIFO_DEPTH = 16;
  localparam int BIT_TIME_CYC = 6;
  // receive sample point inside a bit time, mid-bit after the pin synchronisers
  localparam int RX_TAP_CYC = BIT_TIME_CYC / 2 - 1;
endpackage : cmc_pkg

//--- rtl/cmc_fifo.sv
// small flip-flop fifo with valid/ready on both sides
module cmc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // honest flags from the fill count
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready && ce;
  assign pop = out_valid && out_ready && ce;

  // storage write
  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_q <= cnt_q + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : cmc_fifo

//--- testbench/cmc_stream_model.sv
// far-end serial stream source: frame pulse and repeating receive bytes
module cmc_stream_model
  import cmc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  output logic [NUM_STREAMS-1:0] rx_pin,
  output logic frame_pulse_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FRAME = NUM_CHANNELS * 8 * BIT_TIME_CYC;
  int cyc;

  // byte of channel c on stream s, same in every frame
  function automatic logic rx_bit(int s, int p);
    logic [7:0] b;
    b = 8'((p / 8) * 3 + s * 85);
    return b[7 - p % 8];
  endfunction : rx_bit

  // 128 channels of 8 bits, no input offset applied
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      cyc <= 0;
    else
      cyc <= (cyc == FRAME - 1) ? 0 : cyc + 1;
  end

  // two-cycle pulse so the synchroniser cannot miss the frame start
  assign frame_pulse_pin = cyc < 2;

  // msb first; steady data makes any throughput delay give the same byte
  always_comb
  begin
    for (int s = 0; s < NUM_STREAMS; s++)
      rx_pin[s] = rx_bit(s, cyc / BIT_TIME_CYC);
  end
endmodule : cmc_stream_model

//--- testbench/test_connection_memory_channel_control.sv
// self-checking bench: connection words, switching, loopback, enables
module test_connection_memory_channel_control
  import cmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BT = BIT_TIME_CYC;
  localparam int FRAME = NUM_CHANNELS * 8 * BT;
  typedef struct {int k; int s; int c; logic [7:0] e;} cmc_note_t;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic [10:0] reg_addr = 11'h000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_p = 1'b0;
  logic [15:0] reg_rdata;
  logic [NUM_STREAMS-1:0] rx_pin;
  logic [NUM_STREAMS-1:0] tx_out;
  logic [NUM_STREAMS-1:0] tx_oe;
  logic frame_pulse_pin;
  logic control_channel_out;
  int mismatches = 0;
  int cmp_count = 0;
  int seed = 32'hD4AD6179;
  logic [15:0] rq[$];
  cmc_note_t nq[$];
  logic [7:0] txb[NUM_STREAMS][NUM_CHANNELS];
  logic [NUM_STREAMS-1:0] oes[NUM_CHANNELS];
  logic [NUM_STREAMS-1:0] ccs[NUM_CHANNELS];
  event cap_go;
  event cap_done;

  cmc_top DUT (.clk_sys, .arst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .rx_pin, .frame_pulse_pin, .tx_out, .tx_oe, .control_channel_out);
  cmc_stream_model far_end (.clk_sys, .arst_n, .rx_pin, .frame_pulse_pin);

  initial
    forever #10 clk_sys = ~clk_sys;

  task automatic check(logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  task automatic wr(logic [10:0] a, logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(logic [10:0] a, logic [15:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    rq.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask : rd

  // read data is only valid in the cycle after the strobe
  always @(posedge clk_sys)
  begin
    if (rd_p)
      check(reg_rdata, rq.pop_front());
    rd_p = reg_rd;
  end

  // frame watcher: samples each bit mid-time, then judges pending notes
  initial
  begin
    int p;
    cmc_note_t n;
    forever
    begin
      @cap_go;
      @(posedge frame_pulse_pin);
      for (int k = 1; k < FRAME + 2; k++)
      begin
        @(posedge clk_sys);
        p = (k - BT - 1) / BT;
        if (k % BT == 1 && k > BT)
        begin
          for (int s = 0; s < NUM_STREAMS; s++)
            txb[s][p / 8][7 - p % 8] = tx_out[s];
          if (p % 8 == 4)
            oes[p / 8] = tx_oe;
          if (p % 8 < 4)
            ccs[p / 8][p % 8] = control_channel_out;
        end
      end
      while (nq.size() > 0)
      begin
        n = nq.pop_front();
        if (n.k == 0)
          check(16'(txb[n.s][n.c]), 16'(n.e));
        else if (n.k == 1)
          check(16'(oes[n.c][n.s]), 16'(n.e));
        else
          check(16'(ccs[n.c - 1]), 16'(n.e));
      end
      ->cap_done;
    end
  end

  initial
  begin
    logic [15:0] w;
    logic [15:0] r;
    int s;
    int c;
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd({4'h3, 7'd100}, CONN_RESET);
    nq.push_back('{1, 3, 100, 8'h00});
    // alternate processor and switched channels; last one undriven
    for (int i = 0; i < 6; i++)
    begin
      s = i % NUM_STREAMS;
      c = 20 + i * 16;
      r = 16'($random(seed));
      // unused bits 10:9 written as zero
      w = {1'b0, r[14], i[0], r[12], i != 5, 2'b00, r[8:0]};
      wr({2'b00, s[1:0], c[6:0]}, w);
      rd({2'b00, s[1:0], c[6:0]}, w);
      if (i != 5)
        nq.push_back('{0, s, c, i[0] ? r[7:0] : 8'(r[6:0] * 3 + r[8:7] * 85)});
      nq.push_back('{1, s, c, 8'(i != 5)});
      nq.push_back('{2, s, c, 8'(r[12]) << s});
    end
    // stall the fifo drain for a while, then let it catch up
    wr(ADDR_CTRL, 16'h0001);
    repeat (200) @(posedge clk_sys);
    wr(ADDR_CTRL, 16'h0000);
    wr(11'h403, 16'hFFFF);
    rd(11'h403, 16'h0000);
    repeat (2 * FRAME) @(posedge clk_sys);
    ->cap_go;
    @cap_done;
    // a write while the clock enable is low must be lost
    ce <= 1'b0;
    wr({4'h3, 7'd100}, 16'h0800);
    ce <= 1'b1;
    rd({4'h3, 7'd100}, CONN_RESET);
    // looped stream 0 channel feeds a constant and a variable delay reader
    wr({4'h0, 7'd10}, 16'hA85A);
    wr({4'h2, 7'd40}, 16'h480A);
    wr({4'h3, 7'd41}, 16'h080A);
    nq.push_back('{0, 0, 10, 8'h5A});
    nq.push_back('{0, 2, 40, 8'h5A});
    nq.push_back('{0, 3, 41, 8'h5A});
    repeat (3 * FRAME) @(posedge clk_sys);
    ->cap_go;
    @cap_done;
    tally_and_finish();
  end

  // hang guard, about twice the expected run
  initial
  begin
    repeat (16 * FRAME) @(posedge clk_sys);
    mismatches++;
    tally_and_finish();
  end
endmodule : test_connection_memory_channel_control
